// ==== shared/psfm_regs.vh ====
`ifndef PSFM_REGS_VH
`define PSFM_REGS_VH
// APB byte offsets
`define PSFM_STATUS_OFS 8'h00
`define PSFM_CONTROL_OFS 8'h04
`define PSFM_FLAG_CLR_OFS 8'h08
`define PSFM_FORCE_ERR_OFS 8'h0C
`define PSFM_FORCE_ADDR_OFS 8'h10
`define PSFM_CTL_WRITE_OFS 8'h14
`define PSFM_CTL_ERR_OFS 8'h18
// Control register fields
`define PSFM_CTL_WAIT_EN 0
`define PSFM_CTL_BREQ_EN 1
`define PSFM_CTL_IRQ_EN 2
`define PSFM_CTL_VM 3
`define PSFM_CTL_FAST 4
`define PSFM_CONTROL_RST 5'h03
// Status word bit positions
`define PSFM_ST_BREQ 0
`define PSFM_ST_STOP 1
`define PSFM_ST_WAIT 2
`define PSFM_ST_ABORT 3
`define PSFM_ST_PFAIL 4
`define PSFM_ST_SAT 5
`define PSFM_ST_NMI 6
`define PSFM_ST_NVI 7
`define PSFM_ST_VI 8
`define PSFM_ST_RESET 9
`define PSFM_ST_MI 10
`define PSFM_ST_TMO 11
`define PSFM_ST_ACK_LO 12
// Idle status and error-word sticky bit
`define PSFM_IDLE_STATUS 16'h07EF
`define PSFM_FORCE_STICKY 16
// Watchdog limit in ns and in 10 ns cycles
`define PSFM_WDOG_NS 2000
`define PSFM_CLK_NS 10
`define PSFM_WDOG_CYCLES (`PSFM_WDOG_NS / `PSFM_CLK_NS)
`endif

// ==== hdl/psfm_sync.v ====
`timescale 1ns/100ps
module psfm_sync #(
  parameter W = 14
) (
  clk,
  rst,
  async_in,
  sync_out
);
  input wire clk;
  input wire rst;
  input wire [W-1:0] async_in;
  output wire [W-1:0] sync_out;
  reg [W-1:0] meta;
  reg [W-1:0] stable;
  genvar i;
  // ************************************
  // Two-stage synchroniser per line
  // ************************************
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          meta[i] <= 1'b1;
          stable[i] <= 1'b1;
        end else begin
          meta[i] <= async_in[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate
  assign sync_out = stable;
endmodule // psfm_sync

// ==== hdl/psfm_ack_pulse.v ====
`timescale 1ns/100ps
module psfm_ack_pulse (
  clk,
  rst,
  trigger,
  cycle_start,
  cycle_end,
  ack_n
);
  input wire clk;
  input wire rst;
  input wire trigger;
  input wire cycle_start;
  input wire cycle_end;
  output reg ack_n;
  localparam S_IDLE = 3'b001;
  localparam S_ARM = 3'b010;
  localparam S_DRIVE = 3'b100;
  reg [2:0] state;
  // ************************************
  // One target bus cycle low pulse
  // ************************************
  // Waits for a fresh cycle so the low level covers a whole cycle
  always @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      ack_n <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          if (trigger) begin
            state <= S_ARM;
          end
        end
        S_ARM: begin
          if (cycle_start) begin
            state <= S_DRIVE;
            ack_n <= 1'b0; // RL16
          end
        end
        S_DRIVE: begin
          if (cycle_end) begin
            state <= S_IDLE;
            ack_n <= 1'b1; // RL16
          end
        end
        default: begin
          state <= S_IDLE;
          ack_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // psfm_ack_pulse

// ==== hdl/psfm_top.v ====
// Summary of operation
// RL1 - Status bits 3..0: abort (VM only), wait, stop, bus grant request.
// RL2 - Status bit 2 low means the wait input is active.
// RL3 - Line mirror bits active low; flags at bit 4 and 11-15 active high.
// RL4 - Error words mark faulty lines as one, good lines as zero.
// RL5 - Wait and bus request each have an enable gating them to the CPU.
// RL6 - Both input enables come out of reset enabled.
// RL7 - Disabled wait and bus request are still sampled into status.
// RL8 - Power fail flag high while supply monitor reports out of range.
// RL9 - Timeout flag set when watchdog aborts an access, e.g. fast mode wait.
// RL10 - One acknowledge flag per serviced interrupt type.
// RL11 - Reset, wait, stop, bus request and VM abort are forcing lines.
// RL12 - Asserted forcing line is reported with the access address.
// RL13 - Enabled wait/bus request never count as forcing; disabled ones do.
// RL14 - Interrupt requests pass and are gathered only when enabled.
// RL15 - Interrupt handling is off after reset until enabled.
// RL16 - Control write with bit 0 clear drives acknowledge low one bus cycle.
// RL17 - Control drivability errors use control bit positions, data strobe bit 5.
// RL18 - Special accesses outside normal space are decoded and acted on.
// RL19 - Idle status reads 0000 0111 1110 1111.
// RL20 - 16-bit status word assembled from live samples when read.
`timescale 1ns/100ps
`include "psfm_regs.vh"
module psfm_top #(
  parameter WDOG_CYCLES = `PSFM_WDOG_CYCLES
) (
  clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  wait_n,
  stop_n,
  bus_grant_request_input,
  abort_n,
  target_reset_n,
  mi_n,
  nmi_n,
  plain_irq_input,
  vectored_irq_input,
  segment_trap_input,
  supply_fault,
  access_active,
  access_addr,
  irq_serviced,
  target_cycle_start,
  target_cycle_end,
  ctl_check,
  ctl_expected,
  ctl_observed,
  wait_to_cpu_n,
  breq_to_cpu_n,
  irq_to_cpu_n,
  access_abort,
  force_line_error,
  bus_grant_acknowledge_output
);
  input wire clk;
  input wire rst;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [7:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire wait_n;
  input wire stop_n;
  input wire bus_grant_request_input;
  input wire abort_n;
  input wire target_reset_n;
  input wire mi_n;
  input wire nmi_n;
  input wire plain_irq_input;
  input wire vectored_irq_input;
  input wire segment_trap_input;
  input wire supply_fault;
  input wire access_active;
  input wire [31:0] access_addr;
  input wire [3:0] irq_serviced;
  input wire target_cycle_start;
  input wire target_cycle_end;
  input wire ctl_check;
  input wire [11:0] ctl_expected;
  input wire [11:0] ctl_observed;
  output reg wait_to_cpu_n;
  output reg breq_to_cpu_n;
  output reg [3:0] irq_to_cpu_n;
  output reg access_abort;
  output reg force_line_error;
  output wire bus_grant_acknowledge_output;

  // ************************************
  // Pin synchronisation
  // ************************************
  wire [10:0] pins_raw;
  wire [10:0] pins_s;
  // Supply fault enters inverted so the synchroniser reset value reads as a good supply
  assign pins_raw = {~supply_fault, mi_n, target_reset_n,
                     vectored_irq_input, plain_irq_input, nmi_n,
                     segment_trap_input, abort_n,
                     wait_n, stop_n, bus_grant_request_input};

  psfm_sync #(
    .W(11)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  wire s_wait_n;
  wire s_stop_n;
  wire s_breq_n;
  wire s_abort_n;
  wire s_sat_n;
  wire s_nmi_n;
  wire s_nvi_n;
  wire s_vi_n;
  wire s_reset_n;
  wire s_mi_n;
  wire s_supply_bad;
  assign s_breq_n = pins_s[0];
  assign s_stop_n = pins_s[1];
  assign s_wait_n = pins_s[2];
  assign s_abort_n = pins_s[3];
  assign s_sat_n = pins_s[4];
  assign s_nmi_n = pins_s[5];
  assign s_nvi_n = pins_s[6];
  assign s_vi_n = pins_s[7];
  assign s_reset_n = pins_s[8];
  assign s_mi_n = pins_s[9];
  assign s_supply_bad = ~pins_s[10];

  // ************************************
  // Control register and sticky flags
  // ************************************
  reg [4:0] control;
  reg timeout_flag;
  reg [3:0] ack_flag;
  reg [15:0] force_err;
  reg force_sticky;
  reg [31:0] force_addr;
  reg [11:0] ctl_err;
  reg ctl_write_go;

  wire wait_en;
  wire breq_en;
  wire irq_en;
  wire vm_variant;
  wire fast_mode;
  assign wait_en = control[`PSFM_CTL_WAIT_EN];
  assign breq_en = control[`PSFM_CTL_BREQ_EN];
  assign irq_en = control[`PSFM_CTL_IRQ_EN];
  assign vm_variant = control[`PSFM_CTL_VM];
  assign fast_mode = control[`PSFM_CTL_FAST];

  // ************************************
  // APB decode
  // ************************************
  wire apb_done;
  wire apb_wr;
  wire mapped;
  assign apb_done = psel & penable & pready;
  assign apb_wr = apb_done & pwrite;
  assign mapped = (paddr == `PSFM_STATUS_OFS) |
                  (paddr == `PSFM_CONTROL_OFS) |
                  (paddr == `PSFM_FLAG_CLR_OFS) |
                  (paddr == `PSFM_FORCE_ERR_OFS) |
                  (paddr == `PSFM_FORCE_ADDR_OFS) |
                  (paddr == `PSFM_CTL_WRITE_OFS) |
                  (paddr == `PSFM_CTL_ERR_OFS);

  // ************************************
  // Status word
  // ************************************
  reg [15:0] line_status_word;
  always @* begin
    line_status_word = 16'h0000;
    line_status_word[`PSFM_ST_BREQ] = s_breq_n; // RL1 RL7
    line_status_word[`PSFM_ST_STOP] = s_stop_n; // RL1
    line_status_word[`PSFM_ST_WAIT] = s_wait_n; // RL2 RL7
    // Abort pin is absent on other variants, so it reads inactive
    line_status_word[`PSFM_ST_ABORT] = s_abort_n | ~vm_variant; // RL1
    line_status_word[`PSFM_ST_PFAIL] = s_supply_bad; // RL8
    line_status_word[`PSFM_ST_SAT] = s_sat_n; // RL3
    line_status_word[`PSFM_ST_NMI] = s_nmi_n;
    line_status_word[`PSFM_ST_NVI] = s_nvi_n;
    line_status_word[`PSFM_ST_VI] = s_vi_n;
    line_status_word[`PSFM_ST_RESET] = s_reset_n;
    line_status_word[`PSFM_ST_MI] = s_mi_n;
    line_status_word[`PSFM_ST_TMO] = timeout_flag; // RL3
    line_status_word[15:12] = ack_flag; // RL3 RL10
  end

  // ************************************
  // Forcing line detection
  // ************************************
  // Error word is in status positions, one marks the asserted line
  reg [15:0] force_now;
  always @* begin
    force_now = 16'h0000;
    force_now[`PSFM_ST_RESET] = ~s_reset_n; // RL11 RL4
    force_now[`PSFM_ST_STOP] = ~s_stop_n; // RL11
    force_now[`PSFM_ST_WAIT] = ~s_wait_n & ~wait_en; // RL13
    force_now[`PSFM_ST_BREQ] = ~s_breq_n & ~breq_en; // RL13
    force_now[`PSFM_ST_ABORT] = ~s_abort_n & vm_variant; // RL11
  end

  // ************************************
  // Watchdog
  // ************************************
  localparam WDW = 16;
  reg [WDW-1:0] wdog;
  wire wdog_hit;
  // Only a stuck wait in fast mode can stretch an access this long
  assign wdog_hit = (wdog == WDOG_CYCLES[WDW-1:0] - 16'h0001);

  always @(posedge clk) begin
    if (rst) begin
      wdog <= 16'h0000;
      access_abort <= 1'b0;
    end else begin
      access_abort <= 1'b0;
      if (access_active & fast_mode & ~wait_to_cpu_n & ~access_abort) begin
        if (wdog_hit) begin
          wdog <= 16'h0000;
          access_abort <= 1'b1; // RL9
        end else begin
          wdog <= wdog + 16'h0001;
        end
      end else begin
        wdog <= 16'h0000;
      end
    end
  end

  // ************************************
  // Register writes and flag updates
  // ************************************
  wire flag_clr_wr;
  assign flag_clr_wr = apb_wr & (paddr == `PSFM_FLAG_CLR_OFS);

  always @(posedge clk) begin
    if (rst) begin
      control <= `PSFM_CONTROL_RST; // RL6 RL15
      ctl_write_go <= 1'b0;
    end else begin
      ctl_write_go <= 1'b0;
      if (apb_wr & (paddr == `PSFM_CONTROL_OFS)) begin
        control <= pwdata[4:0];
      end
      if (apb_wr & (paddr == `PSFM_CTL_WRITE_OFS)) begin
        ctl_write_go <= ~pwdata[0]; // RL16 RL18
      end
    end
  end

  // Write one to clear; a set in the same cycle wins
  always @(posedge clk) begin
    if (rst) begin
      timeout_flag <= 1'b0;
      ack_flag <= 4'h0;
    end else begin
      if (access_abort) begin
        timeout_flag <= 1'b1; // RL9
      end else if (flag_clr_wr & pwdata[`PSFM_ST_TMO]) begin
        timeout_flag <= 1'b0;
      end
      ack_flag <= (ack_flag & ~(flag_clr_wr ? pwdata[15:12] : 4'h0))
                  | (irq_en ? irq_serviced : 4'h0); // RL10 RL14
    end
  end

  // Latest error word held until cleared; address kept until the next forcing access, the clear leaves it
  always @(posedge clk) begin
    if (rst) begin
      force_err <= 16'h0000;
      force_sticky <= 1'b0;
      force_addr <= 32'h0000_0000;
      force_line_error <= 1'b0;
    end else begin
      if (access_active & (|force_now)) begin
        force_err <= force_now; // RL12
        force_addr <= access_addr; // RL12
        force_sticky <= 1'b1;
        force_line_error <= 1'b1; // RL12
      end else if (flag_clr_wr & pwdata[`PSFM_FORCE_STICKY]) begin
        force_err <= 16'h0000;
        force_sticky <= 1'b0;
        force_line_error <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ctl_err <= 12'h000;
    end else if (ctl_check) begin
      ctl_err <= ctl_expected ^ ctl_observed; // RL17 RL4
    end
  end

  // ************************************
  // Gated paths to the probe processor
  // ************************************
  always @(posedge clk) begin
    if (rst) begin
      wait_to_cpu_n <= 1'b1;
      breq_to_cpu_n <= 1'b1;
      irq_to_cpu_n <= 4'hF;
    end else begin
      wait_to_cpu_n <= s_wait_n | ~wait_en; // RL5
      breq_to_cpu_n <= s_breq_n | ~breq_en; // RL5
      irq_to_cpu_n <= {s_sat_n, s_vi_n, s_nvi_n, s_nmi_n}
                      | {4{~irq_en}}; // RL14
    end
  end

  // ************************************
  // Bus grant acknowledge
  // ************************************
  psfm_ack_pulse u_ack (
    .clk(clk),
    .rst(rst),
    .trigger(ctl_write_go),
    .cycle_start(target_cycle_start),
    .cycle_end(target_cycle_end),
    .ack_n(bus_grant_acknowledge_output)
  );

  // ************************************
  // APB answer
  // ************************************
  // One wait state keeps pready and prdata straight from flops
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `PSFM_STATUS_OFS: next_prdata = {16'h0000, line_status_word}; // RL20 RL19
      `PSFM_CONTROL_OFS: next_prdata = {27'h0, control};
      `PSFM_FORCE_ERR_OFS: next_prdata = {15'h0, force_sticky, force_err};
      `PSFM_FORCE_ADDR_OFS: next_prdata = force_addr;
      `PSFM_CTL_ERR_OFS: next_prdata = {20'h0, ctl_err};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule // psfm_top

// ==== tb/psfm_sva.sv ====
`timescale 1ns/100ps
module psfm_sva (
  input wire clk,
  input wire rst,
  input wire pready,
  input wire pslverr,
  input wire wait_n,
  input wire bus_grant_request_input,
  input wire nmi_n,
  input wire access_active,
  input wire target_cycle_start,
  input wire target_cycle_end,
  input wire wait_to_cpu_n,
  input wire breq_to_cpu_n,
  input wire [3:0] irq_to_cpu_n,
  input wire access_abort,
  input wire force_line_error,
  input wire bus_grant_acknowledge_output
);
  // ****
  // Port checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  ack_fall_a: assert property ($fell(bus_grant_acknowledge_output) |-> $past(target_cycle_start))
    else $error("ack fell outside bus cycle start");
  ack_rise_a: assert property ($rose(bus_grant_acknowledge_output) |-> $past(target_cycle_end))
    else $error("ack rose outside bus cycle end");
  abort_pulse_a: assert property (access_abort |=> !access_abort) else $error("abort not a pulse");
  abort_cause_a: assert property (access_abort |-> $past(access_active) && !$past(wait_to_cpu_n))
    else $error("abort without stalled access");
  wait_gate_a: assert property (!wait_to_cpu_n |-> !$past(wait_n, 3)) else $error("wait passed wrongly");
  breq_gate_a: assert property (!breq_to_cpu_n |-> !$past(bus_grant_request_input, 3))
    else $error("bus request passed wrongly");
  irq_gate_a: assert property (!irq_to_cpu_n[0] |-> !$past(nmi_n, 3)) else $error("irq passed wrongly");
  force_set_a: assert property ($rose(force_line_error) |-> $past(access_active))
    else $error("forcing error outside access");
  cover property ($fell(bus_grant_acknowledge_output));
  cover property (access_abort);
  cover property ($rose(force_line_error));
endmodule // psfm_sva

bind psfm_top psfm_sva chk (.clk(clk), .rst(rst), .pready(pready), .pslverr(pslverr), .wait_n(wait_n),
  .bus_grant_request_input(bus_grant_request_input), .nmi_n(nmi_n), .access_active(access_active),
  .target_cycle_start(target_cycle_start), .target_cycle_end(target_cycle_end),
  .wait_to_cpu_n(wait_to_cpu_n), .breq_to_cpu_n(breq_to_cpu_n), .irq_to_cpu_n(irq_to_cpu_n),
  .access_abort(access_abort), .force_line_error(force_line_error),
  .bus_grant_acknowledge_output(bus_grant_acknowledge_output));

// ==== tb/psfm_target_model.sv ====
`timescale 1ns/100ps
module psfm_target_model (
  input wire clk,
  input wire rst,
  input wire slow,
  input wire [3:0] irq_to_cpu_n,
  output reg cycle_start,
  output reg cycle_end,
  output reg [3:0] irq_serviced
);
  // ****
  // Target bus cycles and interrupt service
  // ****
  reg [3:0] cnt;
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
      cycle_start <= 1'b0;
      cycle_end <= 1'b0;
      irq_serviced <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
      cycle_start <= (cnt == 4'h0);
      // Slow mode stretches the cycle so a short ack would show
      cycle_end <= (cnt == (slow ? 4'hC : 4'h3));
      irq_serviced <= (cnt == 4'h5) ? ~irq_to_cpu_n : 4'h0;
    end
  end
endmodule // psfm_target_model

// ==== tb/tb_psfm_top.sv ====
`timescale 1ns/100ps
`include "psfm_regs.vh"
module tb_psfm_top;
  // ****
  // Stimulus and checking
  // ****
  localparam int WD = 8;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sfl = 0, act = 0, slow = 0, chk = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, ad = '0;
  logic [15:0] lo = '0, fl = '0;
  logic [11:0] ce = '0, co = '0, e;
  wire [31:0] prdata;
  wire pready, pslverr, cs, cend, wn, bn, abt, fle, ack;
  wire [3:0] irs, irn;
  logic [32:0] q [$];
  int mismatches = 0, checked = 0, n, b;
  psfm_top #(.WDOG_CYCLES(WD)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_n(~lo[2]), .stop_n(~lo[1]), .bus_grant_request_input(~lo[0]), .abort_n(~lo[3]),
    .target_reset_n(~lo[9]), .mi_n(~lo[10]), .nmi_n(~lo[6]), .plain_irq_input(~lo[7]),
    .vectored_irq_input(~lo[8]), .segment_trap_input(~lo[5]), .supply_fault(sfl),
    .access_active(act), .access_addr(ad), .irq_serviced(irs), .target_cycle_start(cs),
    .target_cycle_end(cend), .ctl_check(chk), .ctl_expected(ce), .ctl_observed(co),
    .wait_to_cpu_n(wn), .breq_to_cpu_n(bn), .irq_to_cpu_n(irn), .access_abort(abt),
    .force_line_error(fle), .bus_grant_acknowledge_output(ack));
  psfm_target_model tgt (.clk(clk), .rst(rst), .slow(slow), .irq_to_cpu_n(irn),
    .cycle_start(cs), .cycle_end(cend), .irq_serviced(irs));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmpw(input string nm, input logic [32:0] ex, input logic [32:0] sn);
    checked++;
    if (sn !== ex) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, ex, sn);
    end
  endtask
  task automatic cmpp(input string nm, input logic [3:0] ex, input logic [3:0] sn);
    checked++;
    if (sn !== ex) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, ex, sn);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic er);
    q.push_back({er, d});
    apb(1'b0, a, '0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Line bits low in the mirror, flags high on top
  task automatic rs();
    rd(`PSFM_STATUS_OFS, {16'h0000, `PSFM_IDLE_STATUS & ~lo | fl}, 1'b0);
  endtask
  task automatic acc();
    ad <= $urandom();
    act <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmpw("prdata", q.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(32'h0010));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`PSFM_CONTROL_OFS, 32'h0000_0003, 1'b0);
    rs();
    rd(8'h1C, 32'h0000_0000, 1'b1);
    lo <= 16'h0040;
    repeat (6) @(posedge clk);
    cmpp("irq_n", 4'hF, irn);
    lo <= 16'h0005;
    repeat (5) @(posedge clk);
    cmpp("gate", 4'h0, {2'b00, wn, bn});
    acc();
    rs();
    rd(`PSFM_FORCE_ERR_OFS, 32'h0000_0000, 1'b0);
    wr(`PSFM_CONTROL_OFS, 32'h0000_0008);
    for (int i = 0; i < 5; i++) begin
      b = (i == 4) ? 9 : i;
      lo <= 16'h0001 << b;
      repeat (5) @(posedge clk);
      cmpp("gate", 4'h3, {2'b00, wn, bn});
      acc();
      rs();
      rd(`PSFM_FORCE_ERR_OFS, 32'h0001_0000 | (32'h0000_0001 << b), 1'b0);
      rd(`PSFM_FORCE_ADDR_OFS, ad, 1'b0);
      cmpp("force", 4'h1, 4'(fle));
      lo <= '0;
      wr(`PSFM_FLAG_CLR_OFS, 32'h0001_0000);
    end
    sfl <= 1'b1;
    fl = 16'h0010;
    repeat (5) @(posedge clk);
    rs();
    sfl <= 1'b0;
    fl = '0;
    wr(`PSFM_CONTROL_OFS, 32'h0000_0013);
    lo <= 16'h0004;
    act <= 1'b1;
    for (n = 0; n < 40 && abt !== 1'b1; n++) @(posedge clk);
    cmpp("abort", 4'h1, 4'(abt));
    act <= 1'b0;
    lo <= '0;
    fl = 16'h0800;
    repeat (5) @(posedge clk);
    rs();
    wr(`PSFM_FLAG_CLR_OFS, 32'h0000_0800);
    fl = '0;
    wr(`PSFM_CONTROL_OFS, 32'h0000_0007);
    for (int i = 0; i < 4; i++) begin
      b = (i == 3) ? 5 : i + 6;
      lo <= 16'h0001 << b;
      repeat (5) @(posedge clk);
      cmpp("irq_n", ~(4'h1 << i), irn);
      repeat (20) @(posedge clk);
      lo <= '0;
      fl = 16'h1000 << i;
      repeat (5) @(posedge clk);
      rs();
      wr(`PSFM_FLAG_CLR_OFS, 32'h0000_1000 << i);
      fl = '0;
    end
    wr(`PSFM_CTL_WRITE_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk);
    cmpp("ack", 4'h1, 4'(ack));
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      wr(`PSFM_CTL_WRITE_OFS, 32'h0000_0000);
      for (n = 0; n < 40 && ack !== 1'b0; n++) @(posedge clk);
      cmpp("ack", 4'h0, 4'(ack));
      for (n = 0; n < 40 && ack !== 1'b1; n++) @(posedge clk);
      cmpp("ack", 4'h1, 4'(ack));
      // Low time equals the model's bus cycle from start to end pulse
      cmpp("ack_len", s ? 4'hC : 4'h3, 4'(n));
    end
    e = 12'($urandom());
    ce <= e;
    co <= e ^ 12'h020;
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
    rd(`PSFM_CTL_ERR_OFS, 32'h0000_0020, 1'b0);
    test_done();
  end
endmodule // tb_psfm_top
